// >>> design/rrie_pkg.sv
// Function
// - Return-with-literal matches 11 01xx kkkk kkkk; low byte is literal
// - Return-with-literal loads accumulator with literal, flags untouched
// - Return-with-literal pops stack top into program counter, two cycles
// - Subroutine return matches exactly 00 0000 0000 1000, flags untouched
// - Subroutine return pops stack top into program counter, two cycles
// - Rotate right matches 00 1100 dfff ffff; bit 7 destination, low 7 address
// - Rotate right shifts through carry: carry into MSB, LSB into carry, one cycle
// - Destination 0 writes accumulator; destination 1 writes file register back
package rrie_pkg;
  // ----------------------------------------------------------------
  // Encodings
  // ----------------------------------------------------------------
  localparam int INSTR_W = 14;
  localparam int DATA_W = 8;
  localparam int FADDR_W = 7;
  localparam logic [3:0] RETLIT_TOP = 4'hd;
  localparam logic [13:0] RETURN_CODE = 14'h0008;
  localparam logic [5:0] ROTR_TOP = 6'h0c;
  localparam int DEST_BIT = 7;
  localparam int RET_CYCLES = 2;
  localparam int ROT_CYCLES = 1;
  localparam logic [7:0] ACC_RST = 8'h00;
  localparam logic CARRY_RST = 1'b0;

  typedef enum logic [1:0] {RRIE_OP_NONE, RRIE_OP_RETLIT, RRIE_OP_RETURN, RRIE_OP_ROTR} rrie_op_e;

  // Opcode classification, used by the decoder only; checks match raw patterns
  function automatic rrie_op_e rrie_classify(input logic [13:0] ins);
    if (ins[13:10] == RETLIT_TOP)
      return RRIE_OP_RETLIT;
    else if (ins == RETURN_CODE)
      return RRIE_OP_RETURN;
    else if (ins[13:8] == ROTR_TOP)
      return RRIE_OP_ROTR;
    else
      return RRIE_OP_NONE;
  endfunction
endpackage

// >>> design/rrie_rotator.sv
// ------------------------------------------------------------------
// Rotate right through carry datapath
// ------------------------------------------------------------------
module rrie_rotator #(
  parameter int W = 8
) (
  input wire logic [W-1:0] srcVal,
  input wire logic carryIn,
  output logic [W-1:0] rotVal,
  output logic carryOut
);
  // Old carry enters MSB, old LSB leaves as carry
  assign rotVal = {carryIn, srcVal[W-1:1]};
  assign carryOut = srcVal[0];
endmodule // rrie_rotator

// >>> design/return_rotate_instr_exec.sv
// ------------------------------------------------------------------
// Execute unit for return-with-literal, return and rotate right
// ------------------------------------------------------------------
module return_rotate_instr_exec #(
  parameter int PC_W = 13
) (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic instrValid,
  input wire logic [rrie_pkg::INSTR_W-1:0] instrWord,
  input wire logic [PC_W-1:0] stackTopEntry,
  input wire logic [rrie_pkg::DATA_W-1:0] fileRdData,
  output logic [rrie_pkg::FADDR_W-1:0] fileAddr,
  output logic stackPop,
  output logic pcLoad,
  output logic [PC_W-1:0] pcLoadValue,
  output logic flushFetch,
  output logic busy,
  output logic fileWrEn,
  output logic [rrie_pkg::DATA_W-1:0] fileWrData,
  output logic [rrie_pkg::DATA_W-1:0] accValue,
  output logic carryFlag
);
  import rrie_pkg::*;

  typedef enum logic {RRIE_ST_EXEC, RRIE_ST_REFETCH} rrie_state_e;

  typedef struct packed {
    rrie_state_e st;
    logic [DATA_W-1:0] acc;
    logic carry;
    logic [PC_W-1:0] pcVal;
    logic pcLd;
    logic pop;
    logic fwEn;
    logic [DATA_W-1:0] fwData;
  } rrie_state_s;

  rrie_state_s state_r;
  rrie_state_s state_nxt;
  rrie_op_e op;
  logic [DATA_W-1:0] rotVal;
  logic rotCarry;

  // ----------------------------------------------------------------
  // Decode and rotate datapath
  // ----------------------------------------------------------------
  assign op = instrValid ? rrie_classify(instrWord) : RRIE_OP_NONE;
  assign fileAddr = instrWord[FADDR_W-1:0];

  rrie_rotator #(.W(DATA_W)) u_rot (
    .srcVal(fileRdData),
    .carryIn(state_r.carry),
    .rotVal(rotVal),
    .carryOut(rotCarry)
  );

  // Next state; a new word is ignored while refetching, it is stale
  always_comb
  begin
    state_nxt = state_r;
    state_nxt.pcLd = 1'b0;
    state_nxt.pop = 1'b0;
    state_nxt.fwEn = 1'b0;
    case (state_r.st)
      RRIE_ST_EXEC:
      begin
        case (op)
          RRIE_OP_RETLIT:
          begin
            state_nxt.acc = instrWord[DATA_W-1:0];
            state_nxt.pcVal = stackTopEntry;
            state_nxt.pcLd = 1'b1;
            state_nxt.pop = 1'b1;
            state_nxt.st = RRIE_ST_REFETCH;
          end
          RRIE_OP_RETURN:
          begin
            state_nxt.pcVal = stackTopEntry;
            state_nxt.pcLd = 1'b1;
            state_nxt.pop = 1'b1;
            state_nxt.st = RRIE_ST_REFETCH;
          end
          RRIE_OP_ROTR:
          begin
            state_nxt.carry = rotCarry;
            if (instrWord[DEST_BIT])
            begin
              state_nxt.fwEn = 1'b1;
              state_nxt.fwData = rotVal;
            end
            else
              state_nxt.acc = rotVal;
          end
          default: ;
        endcase
      end
      RRIE_ST_REFETCH:
        state_nxt.st = RRIE_ST_EXEC;
      default:
        state_nxt.st = RRIE_ST_EXEC;
    endcase
  end

  // State register
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      state_r <= '{st: RRIE_ST_EXEC, acc: ACC_RST, carry: CARRY_RST,
                   pcVal: '0, pcLd: 1'b0, pop: 1'b0, fwEn: 1'b0, fwData: '0};
    end
    else
      state_r <= state_nxt;
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign stackPop = state_r.pop;
  assign pcLoad = state_r.pcLd;
  assign pcLoadValue = state_r.pcVal;
  assign flushFetch = (state_r.st == RRIE_ST_REFETCH);
  assign busy = (state_r.st == RRIE_ST_REFETCH);
  assign fileWrEn = state_r.fwEn;
  assign fileWrData = state_r.fwData;
  assign accValue = state_r.acc;
  assign carryFlag = state_r.carry;

  // ----------------------------------------------------------------
  // Checks: return instructions and unknown opcodes
  // ----------------------------------------------------------------
  // Literal lands in the accumulator, carry untouched; raw pattern, not op
  chk_retlit_acc_load: assert property (@(posedge sys_clk) disable iff (!rstn)
    (state_r.st == RRIE_ST_EXEC && instrValid && instrWord[13:10] == RETLIT_TOP)
      |=> accValue == $past(instrWord[DATA_W-1:0]) && carryFlag == $past(carryFlag))
    else $error("literal not loaded");
  // A literal return never touches the file
  chk_retlit_no_write: assert property (@(posedge sys_clk) disable iff (!rstn)
    (state_r.st == RRIE_ST_EXEC && instrValid && instrWord[13:10] == RETLIT_TOP)
      |=> !fileWrEn)
    else $error("literal return wrote file");
  // Don't-care bits 9:8 must not block the pop
  chk_retlit_pop_pc: assert property (@(posedge sys_clk) disable iff (!rstn)
    (state_r.st == RRIE_ST_EXEC && instrValid && instrWord[13:10] == RETLIT_TOP)
      |=> pcLoad && stackPop && pcLoadValue == $past(stackTopEntry))
    else $error("literal return did not pop");
  // Second cycle is the refetch, then free again
  chk_retlit_two_cyc: assert property (@(posedge sys_clk) disable iff (!rstn)
    (state_r.st == RRIE_ST_EXEC && instrValid && instrWord[13:10] == RETLIT_TOP)
      |=> flushFetch ##1 !flushFetch)
    else $error("literal return not two cycles");

  // Exact match only; flags and accumulator kept
  chk_return_match: assert property (@(posedge sys_clk) disable iff (!rstn)
    (state_r.st == RRIE_ST_EXEC && instrValid && instrWord == RETURN_CODE)
      |=> pcLoad && accValue == $past(accValue) && carryFlag == $past(carryFlag))
    else $error("return misdecoded");
  // Plain return also leaves the file alone
  chk_return_no_write: assert property (@(posedge sys_clk) disable iff (!rstn)
    (state_r.st == RRIE_ST_EXEC && instrValid && instrWord == RETURN_CODE)
      |=> !fileWrEn)
    else $error("return wrote file");
  // Popped entry is the one seen with the opcode
  chk_return_pop_pc: assert property (@(posedge sys_clk) disable iff (!rstn)
    (state_r.st == RRIE_ST_EXEC && instrValid && instrWord == RETURN_CODE)
      |=> stackPop && pcLoadValue == $past(stackTopEntry))
    else $error("return did not pop");
  // Two cycles: refetch follows, then the unit is free
  chk_return_two_cyc: assert property (@(posedge sys_clk) disable iff (!rstn)
    (state_r.st == RRIE_ST_EXEC && instrValid && instrWord == RETURN_CODE)
      |=> flushFetch ##1 !flushFetch)
    else $error("return not two cycles");
  // Anything else, near misses of the return code too, is inert
  chk_other_inert: assert property (@(posedge sys_clk) disable iff (!rstn)
    (state_r.st == RRIE_ST_EXEC && instrValid && instrWord[13:10] != RETLIT_TOP
     && instrWord != RETURN_CODE && instrWord[13:8] != ROTR_TOP)
      |=> !pcLoad && !fileWrEn && !flushFetch && accValue == $past(accValue)
          && carryFlag == $past(carryFlag))
    else $error("unknown opcode acted");

  // ----------------------------------------------------------------
  // Checks: rotate
  // ----------------------------------------------------------------
  // File address is the low seven bits
  chk_rotate_decode: assert property (@(posedge sys_clk) disable iff (!rstn)
    (instrValid && instrWord[13:8] == ROTR_TOP) |-> fileAddr == instrWord[FADDR_W-1:0])
    else $error("file address wrong");
  // Carry takes the old LSB
  chk_rotate_carry: assert property (@(posedge sys_clk) disable iff (!rstn)
    (state_r.st == RRIE_ST_EXEC && instrValid && instrWord[13:8] == ROTR_TOP)
      |=> carryFlag == $past(fileRdData[0]))
    else $error("rotate carry wrong");
  // Single cycle: no refetch and no pop behind a rotate
  chk_rotate_one_cyc: assert property (@(posedge sys_clk) disable iff (!rstn)
    (state_r.st == RRIE_ST_EXEC && instrValid && instrWord[13:8] == ROTR_TOP)
      |=> !flushFetch && !pcLoad && !stackPop)
    else $error("rotate not one cycle");
  // Return address is not disturbed by a rotate
  chk_rotate_keep_pc: assert property (@(posedge sys_clk) disable iff (!rstn)
    (state_r.st == RRIE_ST_EXEC && instrValid && instrWord[13:8] == ROTR_TOP)
      |=> pcLoadValue == $past(pcLoadValue))
    else $error("rotate moved return address");
  // Destination 0: accumulator, no write strobe
  chk_rotate_to_acc: assert property (@(posedge sys_clk) disable iff (!rstn)
    (state_r.st == RRIE_ST_EXEC && instrValid && instrWord[13:8] == ROTR_TOP
     && !instrWord[DEST_BIT])
      |=> !fileWrEn && accValue == {$past(carryFlag), $past(fileRdData[DATA_W-1:1])})
    else $error("rotate to accumulator wrong");
  // Destination 1: write back, accumulator kept
  chk_rotate_to_file: assert property (@(posedge sys_clk) disable iff (!rstn)
    (state_r.st == RRIE_ST_EXEC && instrValid && instrWord[13:8] == ROTR_TOP
     && instrWord[DEST_BIT])
      |=> fileWrEn && fileWrData == {$past(carryFlag), $past(fileRdData[DATA_W-1:1])}
          && accValue == $past(accValue))
    else $error("rotate to file wrong");

  // ----------------------------------------------------------------
  // Checks: refetch
  // ----------------------------------------------------------------
  // Stale word during refetch has no effect
  chk_refetch_ignores: assert property (@(posedge sys_clk) disable iff (!rstn)
    flushFetch |=> !pcLoad && !fileWrEn && accValue == $past(accValue))
    else $error("stale word executed");
  // Load, pop and flush travel together
  chk_flush_with_load: assert property (@(posedge sys_clk) disable iff (!rstn)
    pcLoad |-> flushFetch && stackPop)
    else $error("load without flush");
  // Flush is one cycle wide, never two in a row
  chk_flush_single: assert property (@(posedge sys_clk) disable iff (!rstn)
    flushFetch |=> !flushFetch)
    else $error("flush held too long");
endmodule // return_rotate_instr_exec

// >>> dv/tb_return_rotate_instr_exec.sv
module tb_return_rotate_instr_exec;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int PCW = 13;
  logic sysClk = 1'b0;
  logic rstn, instrValid, stackPop, pcLoad, flushFetch, busy, fileWrEn, carryFlag;
  logic [13:0] instrWord;
  logic [PCW-1:0] stackTop, pcLoadValue, mPc;
  logic [7:0] fileRd, fileWrData, accValue, mAcc, mWd, rot;
  logic [6:0] fileAddr;
  logic [13:0] w;
  logic mCarry, mPulse, mWe, busyPrev;
  logic [31:0] seed;
  int err_total = 0;
  int n_checks = 0;
  // ----------------------------------------
  // Clock, device and helpers
  // ----------------------------------------
  // Free running, 100 ns period
  always #50 sysClk = ~sysClk;
  return_rotate_instr_exec #(.PC_W(PCW)) u_dut (.sys_clk(sysClk), .rstn(rstn),
    .instrValid(instrValid), .instrWord(instrWord), .stackTopEntry(stackTop),
    .fileRdData(fileRd), .fileAddr(fileAddr), .stackPop(stackPop), .pcLoad(pcLoad),
    .pcLoadValue(pcLoadValue), .flushFetch(flushFetch), .busy(busy), .fileWrEn(fileWrEn),
    .fileWrData(fileWrData), .accValue(accValue), .carryFlag(carryFlag));
  // Fibonacci style shift, taps 32 22 2 1, deterministic from the seed
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // Case equality so an unknown never matches
  task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // ----------------------------------------
  // Stimulus and reference model
  // ----------------------------------------
  // Random stream keeps back-to-back and flushed words in the mix
  initial
  begin
    {rstn, instrValid, instrWord, stackTop, fileRd} = '0;
    {mAcc, mCarry, mPc, mPulse, mWe, mWd} = '0;
    seed = 32'h3662;
    repeat (4) @(posedge sysClk);
    chk("rstAcc", 16'(accValue), 16'h0000);
    chk("rstPop", 16'(stackPop), 16'h0000);
    rstn <= 1'b1;
    repeat (600)
    begin
      @(posedge sysClk);
      // Model sees the same pre-edge inputs as the device
      busyPrev = mPulse;
      mPulse = 1'b0;
      mWe = 1'b0;
      if (instrValid && !busyPrev)
      begin
        if (instrWord[13:10] == 4'b1101)
        begin
          mAcc = instrWord[7:0];
          mPc = stackTop;
          mPulse = 1'b1;
        end
        else if (instrWord == 14'h0008)
        begin
          mPc = stackTop;
          mPulse = 1'b1;
        end
        else if (instrWord[13:8] == 6'b001100)
        begin
          rot = {mCarry, fileRd[7:1]};
          mCarry = fileRd[0];
          mWe = instrWord[7];
          if (instrWord[7])
            mWd = rot;
          else
            mAcc = rot;
        end
      end
      seed = lfsr(seed);
      case (seed[2:0])
        3'd0, 3'd1: w = {4'hd, seed[13:4]};
        3'd2: w = 14'h0008;
        3'd3, 3'd4, 3'd5: w = {6'h0c, seed[11:4]};
        3'd6: w = seed[3] ? (14'h0008 ^ (14'h0001 << seed[7:4])) : seed[17:4]; // Near misses
        default: w = seed[17:4];
      endcase
      instrWord <= w;
      instrValid <= (seed[2:0] != 3'd7);
      stackTop <= seed[20:8];
      fileRd <= seed[31:24];
      #1;
      chk("stackPop", 16'(stackPop), 16'(mPulse));
      chk("pcLoad", 16'(pcLoad), 16'(mPulse));
      chk("pcLoadValue", 16'(pcLoadValue), 16'(mPc));
      chk("flushFetch", 16'(flushFetch), 16'(mPulse));
      chk("busy", 16'(busy), 16'(mPulse));
      chk("accValue", 16'(accValue), 16'(mAcc));
      chk("carryFlag", 16'(carryFlag), 16'(mCarry));
      chk("fileWrEn", 16'(fileWrEn), 16'(mWe));
      chk("fileAddr", 16'(fileAddr), 16'(instrWord[6:0]));
      if (mWe)
        chk("fileWrData", 16'(fileWrData), 16'(mWd));
    end
    close_out();
  end
  // Watchdog well past the 604 cycles the stream needs
  initial
  begin
    #100000;
    err_total++;
    close_out();
  end
endmodule // tb_return_rotate_instr_exec
